// >>> logic/ccrsd_perf_counter.sv
// External performance event counter
`default_nettype none
module ccrsd_perf_counter import ccrsd_pkg::*; #(
    parameter int COUNT_W = 32
) (
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               rst_sync_n,
    // Event and control
    input  wire logic               event_level,
    input  wire logic               count_enable,
    input  wire logic               count_clear,
    // Result
    output logic [COUNT_W-1:0]      count
);
    if (COUNT_W < 1 || COUNT_W > 64) begin : g_bad_width
        $error("COUNT_W out of range");
    end

    typedef struct packed {
        logic [COUNT_W-1:0] count;
        logic               prev;
    } ccrsd_cnt_state_type;

    ccrsd_cnt_state_type st;
    ccrsd_cnt_state_type next_st;
    logic                event_edge;

    assign event_edge = event_level && !st.prev;

    always_comb begin
        next_st      = st;
        next_st.prev = event_level;
        if (count_clear) begin
            next_st.count = '0;
        end else if (event_edge && count_enable) begin
            next_st.count = st.count + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign count = st.count;

    // ****************************************
    // Checks
    // ****************************************
    a_event_masked: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        (!count_enable || !event_edge) && !count_clear |=> $stable(count))
        else $error("Counter moved without an enabled event");
    a_event_counted: assert property (@(posedge core_clk) disable iff (!rst_sync_n)
        event_edge && count_enable && !count_clear |=> count == $past(count) + 1'b1)
        else $error("Enabled event not counted");
    c_event_count: cover property (@(posedge core_clk) disable iff (!rst_sync_n)
        event_edge && count_enable ##1 1'b1);
endmodule
`default_nettype wire

// >>> logic/ccrsd_pkg.sv
// Constants and types for the clock ratio strap decoder
`default_nettype none
package ccrsd_pkg;
    // ****************************************
    // Ratio codes, printed bit order left to right = bit 5 down to 0
    // ****************************************
    localparam int        CCRSD_CODE_W    = 6;
    localparam logic [5:0] CCRSD_CODE_2X   = 6'h10;
    localparam logic [5:0] CCRSD_CODE_3X   = 6'h20;
    localparam logic [5:0] CCRSD_CODE_4X   = 6'h28;
    localparam logic [5:0] CCRSD_CODE_5X   = 6'h2c;
    localparam logic [5:0] CCRSD_CODE_5P5X = 6'h24;
    localparam logic [5:0] CCRSD_CODE_6X   = 6'h34;
    localparam logic [5:0] CCRSD_CODE_6P5X = 6'h14;
    localparam logic [5:0] CCRSD_CODE_7X   = 6'h08;
    localparam logic [5:0] CCRSD_CODE_7P5X = 6'h04;
    localparam logic [5:0] CCRSD_CODE_8X   = 6'h30;
    localparam logic [5:0] CCRSD_CODE_8P5X = 6'h18;
    localparam logic [5:0] CCRSD_CODE_9X   = 6'h1e;
    localparam logic [5:0] CCRSD_CODE_9P5X = 6'h1c;
    localparam logic [5:0] CCRSD_CODE_10X  = 6'h2a;
    localparam logic [5:0] CCRSD_CODE_10P5X = 6'h22;

    // ****************************************
    // Multipliers in half steps, and fixed values
    // ****************************************
    localparam logic [4:0] CCRSD_HALF_NONE = 5'h00;
    localparam logic [3:0] CCRSD_VCO_MULT  = 4'h1;
    localparam logic [1:0] CCRSD_STRAP_OFF = 2'h0;
    localparam logic [5:0] CCRSD_RST_CODE  = 6'h00;
    localparam logic [1:0] CCRSD_RST_STRAP = 2'h3;
    localparam logic       CCRSD_RST_PROTO = 1'b0;

    typedef enum logic [1:0] {
        CCRSD_STEP_NONE,
        CCRSD_STEP_HALF,
        CCRSD_STEP_QUARTER
    } ccrsd_step_type;

    typedef struct packed {
        logic [4:0]     mult_x2;
        logic           valid;
    } ccrsd_ratio_type;

    // Code to bus-to-core multiplier, counted in halves
    function automatic ccrsd_ratio_type ccrsd_decode(input logic [5:0] code);
        ccrsd_ratio_type r;
        r.valid = 1'b1;
        unique case (code)
            CCRSD_CODE_2X:    r.mult_x2 = 5'h04;
            CCRSD_CODE_3X:    r.mult_x2 = 5'h06;
            CCRSD_CODE_4X:    r.mult_x2 = 5'h08;
            CCRSD_CODE_5X:    r.mult_x2 = 5'h0a;
            CCRSD_CODE_5P5X:  r.mult_x2 = 5'h0b;
            CCRSD_CODE_6X:    r.mult_x2 = 5'h0c;
            CCRSD_CODE_6P5X:  r.mult_x2 = 5'h0d;
            CCRSD_CODE_7X:    r.mult_x2 = 5'h0e;
            CCRSD_CODE_7P5X:  r.mult_x2 = 5'h0f;
            CCRSD_CODE_8X:    r.mult_x2 = 5'h10;
            CCRSD_CODE_8P5X:  r.mult_x2 = 5'h11;
            CCRSD_CODE_9X:    r.mult_x2 = 5'h12;
            CCRSD_CODE_9P5X:  r.mult_x2 = 5'h13;
            CCRSD_CODE_10X:   r.mult_x2 = 5'h14;
            CCRSD_CODE_10P5X: r.mult_x2 = 5'h15;
            default: begin
                r.mult_x2 = CCRSD_HALF_NONE;
                r.valid   = 1'b0;
            end
        endcase
        return r;
    endfunction
endpackage
`default_nettype wire

// >>> logic/ccrsd_top.sv
// Strap decoder: bus-to-core ratio, step-down, bus protocol, perf event
// ****************************************
// Overview of operation
// - Core clock is bus clock times decoded ratio; core-to-oscillator multiplier always 1x.
// - Codes 010000,100000,101000,101100,100100 give 2x,3x,4x,5x,5.5x.
// - Step-down halves or quarters the chosen multiplier, lowering core clock.
// - Both step-down straps low at hard reset lock step-down off despite software, until a logic reset or the next hard reset.
// - Protocol pin sampled at hard reset release: high multiplexed, low legacy.
// - External perf event input counts only when software enables it.
// ****************************************
`default_nettype none
module ccrsd_top import ccrsd_pkg::*; #(
    parameter int PERF_COUNT_W = 32
) (
    // Clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rstn,
    // Straps and reset from the board
    input  wire logic                   hard_reset_in_n,
    input  wire logic [5:0]             ratio_code,
    input  wire logic [1:0]             freq_step_down_strap,
    input  wire logic                   bus_mode_sel,
    input  wire logic                   perf_event_in_n,
    // Software controls
    input  wire logic                   sw_step_down_half,
    input  wire logic                   sw_step_down_quarter,
    input  wire logic                   sw_perf_enable,
    input  wire logic                   sw_perf_clear,
    // Decoded clock settings
    output logic [4:0]                  mult_x2,
    output logic                        ratio_valid,
    output logic [3:0]                  core_vco_mult,
    output logic                        step_down_allowed,
    output ccrsd_step_type              step_mode,
    output logic [6:0]                  eff_mult_x8,
    // Bus protocol and performance count
    output logic                        multiplexed_bus_protocol,
    output logic [PERF_COUNT_W-1:0]     perf_count
);
    if (PERF_COUNT_W < 1 || PERF_COUNT_W > 64) begin : g_bad_width
        $error("PERF_COUNT_W out of range");
    end

    // ****************************************
    // Reset release
    // ****************************************
    logic [1:0] rst_pipe;
    logic       rst_sync_n;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_pipe <= 2'b00;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_sync_n = rst_pipe[1];

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [5:0]     code;
        logic [1:0]     strap;
        logic           hr_prev;
        logic           proto;
        logic [4:0]     mult_x2;
        logic           valid;
        ccrsd_step_type mode;
        logic [6:0]     eff;
    } ccrsd_state_type;

    ccrsd_state_type st;
    ccrsd_state_type next_st;
    ccrsd_ratio_type dec;

    always_comb begin
        next_st         = st;
        next_st.hr_prev = hard_reset_in_n;
        // Straps follow the pins only while hard reset is low
        if (!hard_reset_in_n) begin
            next_st.code  = ratio_code;
            next_st.strap = freq_step_down_strap;
        end
        // Only the release edge counts; later pin motion is ignored
        if (hard_reset_in_n && !st.hr_prev) begin
            next_st.proto = bus_mode_sel;
        end
        dec             = ccrsd_decode(next_st.code);
        next_st.mult_x2 = dec.mult_x2;
        next_st.valid   = dec.valid;
        // Straps both low override any software request
        if (next_st.strap == CCRSD_STRAP_OFF) begin
            next_st.mode = CCRSD_STEP_NONE;
        end else if (sw_step_down_quarter) begin
            next_st.mode = CCRSD_STEP_QUARTER;
        end else if (sw_step_down_half) begin
            next_st.mode = CCRSD_STEP_HALF;
        end else begin
            next_st.mode = CCRSD_STEP_NONE;
        end
        // Eighths keep 10.5x / 4 exact
        unique case (next_st.mode)
            CCRSD_STEP_HALF:    next_st.eff = {1'b0, dec.mult_x2, 1'b0};
            CCRSD_STEP_QUARTER: next_st.eff = {2'b00, dec.mult_x2};
            default:            next_st.eff = {dec.mult_x2, 2'b00};
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st.code    <= CCRSD_RST_CODE;
            st.strap   <= CCRSD_RST_STRAP;
            // Idle pin level, so no false release edge follows a logic reset
            st.hr_prev <= 1'b1;
            st.proto   <= CCRSD_RST_PROTO;
            st.mult_x2 <= CCRSD_HALF_NONE;
            st.valid   <= 1'b0;
            st.mode    <= CCRSD_STEP_NONE;
            st.eff     <= 7'h00;
        end else begin
            st <= next_st;
        end
    end

    assign mult_x2                  = st.mult_x2;
    assign ratio_valid              = st.valid;
    assign core_vco_mult            = CCRSD_VCO_MULT;
    assign step_down_allowed        = st.strap != CCRSD_STRAP_OFF;
    assign step_mode                = st.mode;
    assign eff_mult_x8              = st.eff;
    assign multiplexed_bus_protocol = st.proto;

    // ****************************************
    // Performance event
    // ****************************************
    ccrsd_perf_counter #(
        .COUNT_W     (PERF_COUNT_W)
    ) u_perf (
        .core_clk    (core_clk),
        .rst_sync_n  (rst_sync_n),
        .event_level (!perf_event_in_n),
        .count_enable(sw_perf_enable),
        .count_clear (sw_perf_clear),
        .count       (perf_count)
    );

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_sync_n);

    a_vco_mult_one: assert property (core_vco_mult == 4'h1 &&
        (st.mode != CCRSD_STEP_NONE || eff_mult_x8 == {mult_x2, 2'b00}))
        else $error("Unstepped multiplier or oscillator ratio wrong");
    a_decode_low_set: assert property (!hard_reset_in_n && ratio_code == CCRSD_CODE_5P5X
        |=> mult_x2 == 5'h0b && ratio_valid)
        else $error("5.5x code decoded wrong");
    a_decode_mid_set: assert property (!hard_reset_in_n && ratio_code == CCRSD_CODE_7P5X
        |=> mult_x2 == 5'h0f && ratio_valid)
        else $error("7.5x code decoded wrong");
    a_decode_high_set: assert property (!hard_reset_in_n && ratio_code == CCRSD_CODE_10P5X
        |=> mult_x2 == 5'h15 && ratio_valid)
        else $error("10.5x code decoded wrong");
    a_decode_two: assert property (!hard_reset_in_n && ratio_code == CCRSD_CODE_2X
        |=> mult_x2 == 5'h04 && ratio_valid)
        else $error("2x code decoded wrong");
    a_decode_three: assert property (!hard_reset_in_n && ratio_code == CCRSD_CODE_3X
        |=> mult_x2 == 5'h06 && ratio_valid)
        else $error("3x code decoded wrong");
    a_decode_seven: assert property (!hard_reset_in_n && ratio_code == CCRSD_CODE_7X
        |=> mult_x2 == 5'h0e && ratio_valid)
        else $error("7x code decoded wrong");
    a_decode_nine: assert property (!hard_reset_in_n && ratio_code == CCRSD_CODE_9X
        |=> mult_x2 == 5'h12 && ratio_valid)
        else $error("9x code decoded wrong");
    a_decode_unlisted: assert property (!hard_reset_in_n
        && (ratio_code[0] || (ratio_code[5] && ratio_code[2] && ratio_code[1]))
        |=> !ratio_valid && mult_x2 == 5'h00 && eff_mult_x8 == 7'h00)
        else $error("Unlisted code not refused");

    a_step_quarter: assert property (step_down_allowed && sw_step_down_quarter
        && hard_reset_in_n |=> eff_mult_x8 == {2'b00, mult_x2})
        else $error("Quarter step-down not applied");
    a_step_half: assert property (step_down_allowed && sw_step_down_half
        && !sw_step_down_quarter && hard_reset_in_n
        |=> step_mode == CCRSD_STEP_HALF && eff_mult_x8 == {1'b0, mult_x2, 1'b0})
        else $error("Half step-down not applied");
    a_step_none: assert property (hard_reset_in_n && !sw_step_down_half
        && !sw_step_down_quarter |=> step_mode == CCRSD_STEP_NONE
        && eff_mult_x8 == {mult_x2, 2'b00})
        else $error("Multiplier stepped without a request");
    a_step_locked: assert property (hard_reset_in_n && freq_step_down_strap == 2'b00
        && st.strap == 2'b00 |=> step_mode == CCRSD_STEP_NONE)
        else $error("Step-down active with straps low");
    a_step_strap_low: assert property (!hard_reset_in_n && freq_step_down_strap == 2'b00
        |=> step_mode == CCRSD_STEP_NONE && !step_down_allowed)
        else $error("Step-down not locked by low straps");

    a_proto_sample: assert property ($rose(hard_reset_in_n)
        |=> multiplexed_bus_protocol == $past(bus_mode_sel))
        else $error("Protocol not sampled at hard reset release");
    a_proto_hold: assert property (!$rose(hard_reset_in_n)
        |=> $stable(multiplexed_bus_protocol))
        else $error("Protocol moved without hard reset release");
    a_strap_hold: assert property (hard_reset_in_n && $past(hard_reset_in_n)
        |-> $stable(st.code) && $stable(st.strap) ##1 $stable(mult_x2))
        else $error("Latched straps moved outside hard reset");
    a_strap_follow: assert property (!hard_reset_in_n
        |=> step_down_allowed == ($past(freq_step_down_strap) != 2'b00))
        else $error("Straps not captured during hard reset");

    // ****************************************
    // Main scenarios
    // ****************************************
    c_hard_release: cover property (!hard_reset_in_n ##1 hard_reset_in_n[*3]);
    c_quarter_mode: cover property (step_mode == CCRSD_STEP_QUARTER);
    c_mux_protocol: cover property ($rose(hard_reset_in_n) && bus_mode_sel);
    c_locked_request: cover property (!step_down_allowed && sw_step_down_quarter);
endmodule
`default_nettype wire

// >>> testbench/ccrsd_board_model.sv
// Board model: straps, hard reset and event pin as the system drives them
`default_nettype none
module ccrsd_board_model import ccrsd_pkg::*; (
    // Bench requests
    input  wire logic       hr,
    input  wire logic [5:0] code,
    input  wire logic [1:0] st,
    input  wire logic       sel,
    input  wire logic       ev_n,
    // Board pins
    output logic            hard_reset_in_n,
    output logic [5:0]      ratio_code,
    output logic [1:0]      freq_step_down_strap,
    output logic            bus_mode_sel,
    output logic            perf_event_in_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic test_rst_n;
    assign hard_reset_in_n      = ~hr;
    // Test-port reset simply follows hard reset
    assign test_rst_n           = hard_reset_in_n;
    // Factory bit strapped low; the upper five code bits pass through, unlisted codes included
    assign ratio_code           = {code[5:1], 1'b0};
    assign freq_step_down_strap = st;
    assign bus_mode_sel         = sel;
    // Event pin kept negated while hard reset is active
    assign perf_event_in_n      = hr | ev_n;
endmodule
`default_nettype wire

// >>> testbench/core_clock_ratio_strap_decode_tb.sv
// Self-checking bench for the clock ratio strap decoder
`default_nettype none
module core_clock_ratio_strap_decode_tb import ccrsd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0, rstn = 1'b0, hr = 1'b0, sel = 1'b0, ev_n = 1'b1;
    logic sw_h = 1'b0, sw_q = 1'b0, sw_en = 1'b0, sw_clr = 1'b0;
    logic [5:0] code = 6'h00;
    logic [1:0] st = 2'h3;
    wire logic hrn, msel, evn;
    wire logic [5:0] rc;
    wire logic [1:0] rst;
    logic [4:0] mult_x2;
    logic ratio_valid, step_down_allowed, multiplexed_bus_protocol;
    logic [3:0] core_vco_mult;
    ccrsd_step_type step_mode;
    logic [6:0] eff_mult_x8;
    logic [31:0] perf_count;
    int fails = 0, cmp_count = 0, cyc = 0;
    logic [10:0] rows [16] = '{
        {6'h10, 5'h04}, {6'h20, 5'h06}, {6'h28, 5'h08}, {6'h2c, 5'h0a},
        {6'h24, 5'h0b}, {6'h34, 5'h0c}, {6'h14, 5'h0d}, {6'h08, 5'h0e},
        {6'h04, 5'h0f}, {6'h30, 5'h10}, {6'h18, 5'h11}, {6'h1e, 5'h12},
        {6'h1c, 5'h13}, {6'h2a, 5'h14}, {6'h22, 5'h15}, {6'h3e, 5'h00}};

    always #20 core_clk = ~core_clk;

    ccrsd_board_model u_board (.hr(hr), .code(code), .st(st), .sel(sel), .ev_n(ev_n),
        .hard_reset_in_n(hrn), .ratio_code(rc), .freq_step_down_strap(rst),
        .bus_mode_sel(msel), .perf_event_in_n(evn));

    ccrsd_top u_dut (.core_clk(core_clk), .rstn(rstn), .hard_reset_in_n(hrn),
        .ratio_code(rc), .freq_step_down_strap(rst), .bus_mode_sel(msel),
        .perf_event_in_n(evn), .sw_step_down_half(sw_h), .sw_step_down_quarter(sw_q),
        .sw_perf_enable(sw_en), .sw_perf_clear(sw_clr), .mult_x2(mult_x2),
        .ratio_valid(ratio_valid), .core_vco_mult(core_vco_mult),
        .step_down_allowed(step_down_allowed), .step_mode(step_mode),
        .eff_mult_x8(eff_mult_x8), .multiplexed_bus_protocol(multiplexed_bus_protocol),
        .perf_count(perf_count));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        if (fails == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask

    // Two edges in hard reset, then release and let the protocol sample land
    task automatic hard_rst(input logic [5:0] c, input logic [1:0] s, input logic m);
        hr = 1'b1;
        code = c;
        st = s;
        sel = m;
        tick(2);
        hr = 1'b0;
        tick(2);
    endtask

    task automatic pulse();
        ev_n = 1'b0;
        tick(2);
        ev_n = 1'b1;
        tick(2);
    endtask

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            conclude();
        end
    end

    initial begin
        tick(3);
        chk(32'(mult_x2), 32'h0);
        chk(32'(step_mode), 32'(CCRSD_STEP_NONE));
        chk(32'(multiplexed_bus_protocol), 32'h0);
        chk(perf_count, 32'h0);
        rstn = 1'b1;
        tick(3);
        // ****************************************
        // Ratio table, step-down off by software
        // ****************************************
        foreach (rows[i]) begin
            hard_rst(rows[i][10:5], 2'h3, 1'b0);
            chk(32'(mult_x2), 32'(rows[i][4:0]));
            chk(32'(ratio_valid), 32'(rows[i][4:0] != 5'h00));
            chk(32'(eff_mult_x8), 32'(rows[i][4:0]) * 4);
            chk(32'(core_vco_mult), 32'h1);
        end
        // ****************************************
        // Awkward cases
        // ****************************************
        hard_rst(6'h22, 2'h3, 1'b1);
        chk(32'(multiplexed_bus_protocol), 32'h1);
        code = 6'h10;
        st = 2'h0;
        sel = 1'b0;
        tick(3);
        chk(32'(mult_x2), 32'h15);
        chk(32'(step_down_allowed), 32'h1);
        chk(32'(multiplexed_bus_protocol), 32'h1);
        sw_h = 1'b1;
        tick(2);
        chk(32'(step_mode), 32'(CCRSD_STEP_HALF));
        chk(32'(eff_mult_x8), 32'd42);
        sw_q = 1'b1;
        tick(2);
        chk(32'(step_mode), 32'(CCRSD_STEP_QUARTER));
        chk(32'(eff_mult_x8), 32'd21);
        hard_rst(6'h22, 2'h0, 1'b0);
        chk(32'(multiplexed_bus_protocol), 32'h0);
        chk(32'(step_down_allowed), 32'h0);
        chk(32'(step_mode), 32'(CCRSD_STEP_NONE));
        chk(32'(eff_mult_x8), 32'd84);
        sw_q = 1'b0;
        sw_h = 1'b0;
        pulse();
        chk(perf_count, 32'h0);
        sw_en = 1'b1;
        repeat (3) pulse();
        chk(perf_count, 32'h3);
        // Clear held across an event, so the event must not count
        sw_clr = 1'b1;
        pulse();
        sw_clr = 1'b0;
        chk(perf_count, 32'h0);
        pulse();
        chk(perf_count, 32'h1);
        // Mid-run logic reset, hard reset idle and protocol pin high
        hard_rst(6'h2c, 2'h1, 1'b1);
        chk(32'(step_down_allowed), 32'h1);
        rstn = 1'b0;
        tick(1);
        chk(32'(mult_x2), 32'h0);
        chk(32'(multiplexed_bus_protocol), 32'h0);
        chk(perf_count, 32'h0);
        rstn = 1'b1;
        tick(3);
        chk(32'(multiplexed_bus_protocol), 32'h0);
        chk(32'(ratio_valid), 32'h0);
        hard_rst(6'h2c, 2'h3, 1'b1);
        chk(32'(mult_x2), 32'h0a);
        chk(32'(multiplexed_bus_protocol), 32'h1);
        conclude();
    end
endmodule
`default_nettype wire
